// [hw/rsc_reset_sleep.sv]
// reset combining, startup delay, watchdog and sleep control with apb registers
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module rsc_reset_sleep #(
  parameter int unsigned TOUT0_CYC = rsc_pkg::TOUT0_CYCLES,
  parameter int unsigned TOUT1_CYC = rsc_pkg::TOUT1_CYCLES,
  parameter int unsigned TOUT2_CYC = rsc_pkg::TOUT2_CYCLES,
  parameter int unsigned TOUT3_CYC = rsc_pkg::TOUT3_CYCLES,
  parameter int unsigned WD_BASE   = rsc_pkg::WD_BASE_CYCLES,
  parameter int unsigned TOUT_W    = 24,
  parameter int unsigned WD_W      = 22
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // reset sources, asynchronous
  input  wire logic        resetPinN,
  input  wire logic        supplyRiseDet,
  input  wire logic        brownoutDet,
  input  wire logic        jtagResetReg,
  input  wire logic        wdOscClk,
  // fuses and clock option, static
  input  wire logic [1:0]  startupDelayFuse,
  input  wire logic        brownoutEnableFuse,
  input  wire logic        extClockSel,
  // core side, same clock
  input  wire logic        sleepInstr,
  input  wire logic        watchdogResetInstr,
  input  wire logic        compBandgapSel,
  input  wire logic        converterEnable,
  // results
  output logic             ioPortReset,
  output logic             coreReset,
  output logic             sleepEnter,
  output logic      [2:0]  sleepMode,
  output logic             bandgapEnable
);

  logic [4:0]        syncA_r;
  logic [4:0]        syncB_r;
  logic              wdOscPrev_r;
  logic              pinRst;
  logic              supRst;
  logic              boRst;
  logic              jtRst;
  logic              srcActive;
  logic              coreReset_r;
  logic [TOUT_W-1:0] toutCnt_r;
  logic [TOUT_W-1:0] toutLimit;
  logic [1:0]        delayFuse_r;
  logic              boEnFuse_r;
  logic [7:0]        sleepCtrl_r;
  logic              wdEn_r;
  logic              watchdog_turnoff_enable_r;
  logic [1:0]        toeCnt_r;
  logic [2:0]        wdPre_r;
  logic [WD_W-1:0]   wdCnt_r;
  logic [WD_W-1:0]   wdLimit;
  logic              wdOscEdge;
  logic              wdExpire;
  logic              wdPulse_r;
  logic [4:0]        cause_r;
  logic [4:0]        cause_nxt;
  logic              sleepEnter_r;
  logic              bandgap_r;
  logic [31:0]       prdata_r;
  logic              wrAcc;
  logic              hitSleep;
  logic              hitCause;
  logic              hitWd;
  logic              addrHit;
  logic              wdWrite;
  logic              modeOk;

  // pins and the watchdog oscillator pass two flops before use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA_r <= 5'h01;  // pin bit idles high, so leaving reset is no pin reset
      syncB_r <= 5'h01;
    end else begin
      syncA_r <= {wdOscClk, jtagResetReg, brownoutDet, supplyRiseDet, resetPinN};
      syncB_r <= syncA_r;
    end
  end

  assign pinRst    = ~syncB_r[0];
  assign supRst    = syncB_r[1];
  assign boRst     = syncB_r[2] & boEnFuse_r;
  assign jtRst     = syncB_r[3];
  assign srcActive = pinRst | supRst | boRst | jtRst | wdPulse_r;

  // ports see raw sources so they reset even with the clock stopped; the synced
  // sources keep them held until the core has seen the release too
  assign ioPortReset = rst | ~resetPinN | supplyRiseDet | (brownoutDet & brownoutEnableFuse)
                     | jtagResetReg | srcActive;

  // any active source forces the core reset in the same cycle, no delay
  assign coreReset = coreReset_r | srcActive;

  // fuses are only sampled while reset is held, so a glitch later cannot move them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      delayFuse_r <= 2'h0;
      boEnFuse_r  <= 1'b0;
    end else if (coreReset) begin
      delayFuse_r <= startupDelayFuse;
      boEnFuse_r  <= brownoutEnableFuse;
    end
  end

  // startup delay length chosen by the fuse
  always_comb begin
    case (delayFuse_r)
      2'h0:    toutLimit = TOUT_W'(TOUT0_CYC);
      2'h1:    toutLimit = TOUT_W'(TOUT1_CYC);
      2'h2:    toutLimit = TOUT_W'(TOUT2_CYC);
      default: toutLimit = TOUT_W'(TOUT3_CYC);
    endcase
  end

  // delay counter: cleared by any active source, releases after the full period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      coreReset_r <= 1'b1;
      toutCnt_r   <= '0;
    end else if (srcActive) begin
      coreReset_r <= 1'b1;
      toutCnt_r   <= '0;
    end else if (coreReset_r) begin
      if (toutCnt_r >= toutLimit - TOUT_W'(1)) begin
        coreReset_r <= 1'b0;
      end else begin
        toutCnt_r <= toutCnt_r + TOUT_W'(1);
      end
    end
  end

  // apb decode; zero wait states so pready is always high
  assign hitSleep = (paddr == rsc_pkg::SLEEP_CTRL_OFS);
  assign hitCause = (paddr == rsc_pkg::CAUSE_OFS);
  assign hitWd    = (paddr == rsc_pkg::WD_CTRL_OFS);
  assign addrHit  = hitSleep | hitCause | hitWd;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~addrHit;
  assign wrAcc    = psel & penable & pwrite & pstrb[0] & addrHit;
  assign wdWrite  = wrAcc & hitWd;

  // power_sleep_control: returns to its initial value while reset holds
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleepCtrl_r <= rsc_pkg::SLEEP_CTRL_RST;
    end else if (coreReset) begin
      sleepCtrl_r <= rsc_pkg::SLEEP_CTRL_RST;
    end else if (wrAcc && hitSleep) begin
      sleepCtrl_r <= pwdata[7:0];
    end
  end

  // watchdog control; disabling needs the armed turn-off window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdEn_r   <= 1'b0;
      watchdog_turnoff_enable_r  <= 1'b0;
      toeCnt_r <= 2'h0;
      wdPre_r  <= rsc_pkg::WD_PRE_RST;
    end else if (coreReset) begin
      wdEn_r   <= 1'b0;
      watchdog_turnoff_enable_r  <= 1'b0;
      toeCnt_r <= 2'h0;
      wdPre_r  <= rsc_pkg::WD_PRE_RST;
    end else begin
      if (wdWrite && pwdata[rsc_pkg::WD_TOE_BIT] && pwdata[rsc_pkg::WD_EN_BIT]) begin
        watchdog_turnoff_enable_r  <= 1'b1;
        toeCnt_r <= 2'h0;
      end else if (watchdog_turnoff_enable_r && toeCnt_r == rsc_pkg::TOE_LAST) begin
        watchdog_turnoff_enable_r  <= 1'b0;
      end else if (watchdog_turnoff_enable_r) begin
        toeCnt_r <= toeCnt_r + 2'h1;
      end
      if (wdWrite) begin
        wdPre_r <= pwdata[rsc_pkg::WD_PRE_LSB +: 3];
        if (pwdata[rsc_pkg::WD_EN_BIT]) begin
          wdEn_r <= 1'b1;
        end else if (watchdog_turnoff_enable_r) begin
          wdEn_r <= 1'b0;
        end
      end
    end
  end

  // oscillator edge; the third flop only delays the already synchronised level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdOscPrev_r <= 1'b0;
    end else begin
      wdOscPrev_r <= syncB_r[4];
    end
  end

  assign wdOscEdge = syncB_r[4] & ~wdOscPrev_r;
  assign wdLimit   = WD_W'(WD_BASE) << wdPre_r;
  assign wdExpire  = wdEn_r & wdOscEdge & (wdCnt_r == wdLimit - WD_W'(1))
                   & ~watchdogResetInstr & ~coreReset;

  // watchdog counter; oscillator must run well below clk/2 for edges to be seen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdCnt_r <= '0;
    end else if (coreReset || !wdEn_r || watchdogResetInstr) begin
      wdCnt_r <= '0;
    end else if (wdOscEdge) begin
      wdCnt_r <= wdExpire ? '0 : wdCnt_r + WD_W'(1);
    end
  end

  // the pulse itself resets the core, which disables the watchdog, so it lasts one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdPulse_r <= 1'b0;
    end else begin
      wdPulse_r <= wdExpire;
    end
  end

  // reset cause flags: set beats clear, supply rise clears the other four
  always_comb begin
    cause_nxt = cause_r;
    if (wrAcc && hitCause) begin
      cause_nxt = cause_nxt & pwdata[4:0];
    end
    if (supRst) begin
      cause_nxt[4:1] = 4'h0;
    end
    if (jtRst) begin
      cause_nxt[rsc_pkg::JTAG_FLAG_BIT] = 1'b1;
    end
    if (wdPulse_r) begin
      cause_nxt[rsc_pkg::WD_FLAG_BIT] = 1'b1;
    end
    if (boRst) begin
      cause_nxt[rsc_pkg::BO_FLAG_BIT] = 1'b1;
    end
    if (pinRst) begin
      cause_nxt[rsc_pkg::PIN_FLAG_BIT] = 1'b1;
    end
    if (supRst) begin
      cause_nxt[rsc_pkg::SUP_FLAG_BIT] = 1'b1;
    end
  end

  // flags survive the internal reset so software can read the cause afterwards
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cause_r <= rsc_pkg::CAUSE_RST;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  // sleep entry: enable bit, a legal mode, and a crystal for the standby modes
  always_comb begin
    case (sleepCtrl_r[rsc_pkg::SLEEP_MODE_LSB +: 3])
      rsc_pkg::MODE_RSVD0, rsc_pkg::MODE_RSVD1: modeOk = 1'b0;
      rsc_pkg::MODE_STBY, rsc_pkg::MODE_XSTBY:  modeOk = extClockSel;
      default:                                  modeOk = 1'b1;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleepEnter_r <= 1'b0;
    end else begin
      sleepEnter_r <= sleepInstr & sleepCtrl_r[rsc_pkg::SLEEP_EN_BIT] & modeOk
                    & ~coreReset;
    end
  end

  assign sleepEnter = sleepEnter_r;
  assign sleepMode  = sleepCtrl_r[rsc_pkg::SLEEP_MODE_LSB +: 3];

  // bandgap request, registered to keep the analog enable glitch free
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bandgap_r <= 1'b0;
    end else begin
      bandgap_r <= boEnFuse_r | compBandgapSel | converterEnable;
    end
  end

  assign bandgapEnable = bandgap_r;

  // read data captured in the setup cycle, held through the access cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable) begin
      if (hitSleep) begin
        prdata_r <= {24'h00_0000, sleepCtrl_r};
      end else if (hitCause) begin
        prdata_r <= {27'h000_0000, cause_r};
      end else if (hitWd) begin
        prdata_r <= {27'h000_0000, watchdog_turnoff_enable_r, wdEn_r, wdPre_r};
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  assign prdata = prdata_r;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sleep_gate_a: assert property (sleepEnter |-> $past(sleepInstr)
      && $past(sleepCtrl_r[rsc_pkg::SLEEP_EN_BIT])) else $error("sleep without enable");
  mode_rsvd_a: assert property (sleepEnter |-> $past(sleepMode) != rsc_pkg::MODE_RSVD0
      && $past(sleepMode) != rsc_pkg::MODE_RSVD1) else $error("reserved mode slept");
  standby_clk_a: assert property (sleepEnter && $past(sleepMode[2:1]) == 2'h3
      |-> $past(extClockSel)) else $error("standby without crystal");
  regs_init_a: assert property (coreReset |=> sleepCtrl_r == rsc_pkg::SLEEP_CTRL_RST && !wdEn_r)
      else $error("register kept during reset");
  port_reset_a: assert property (srcActive |-> ioPortReset)
      else $error("port reset missing");
  release_delay_a: assert property ($fell(coreReset_r) |-> $past(toutCnt_r) ==
      toutLimit - TOUT_W'(1) && $past(!srcActive)) else $error("early release");
  jtag_hold_a: assert property (jtRst |-> coreReset)
      else $error("jtag reset not held");
  supply_now_a: assert property ($rose(supRst) |-> coreReset ##1 coreReset_r && toutCnt_r == 0)
      else $error("supply reset delayed");
  wd_pulse_a: assert property (wdPulse_r |=> !wdPulse_r && coreReset_r && toutCnt_r == 0)
      else $error("watchdog pulse width");
  bandgap_or_a: assert property (##1 bandgapEnable ==
      ($past(boEnFuse_r) | $past(compBandgapSel) | $past(converterEnable)))
      else $error("bandgap enable wrong");
  wd_disable_a: assert property ($fell(wdEn_r) |-> $past(watchdog_turnoff_enable_r) || $past(coreReset))
      else $error("watchdog disabled plainly");
  toe_expire_a: assert property (watchdog_turnoff_enable_r && toeCnt_r == rsc_pkg::TOE_LAST && !wdWrite
      |=> !watchdog_turnoff_enable_r) else $error("turn-off window too long");
  wd_flag_a: assert property (wdPulse_r |=> cause_r[rsc_pkg::WD_FLAG_BIT])
      else $error("watchdog flag not set");
  // flags set by their sources, brown-out reset at once, counter clears and delay restart
  jtag_flag_a: assert property (jtRst |=> cause_r[rsc_pkg::JTAG_FLAG_BIT])
      else $error("jtag flag not set");
  pin_flag_a: assert property (pinRst |=> cause_r[rsc_pkg::PIN_FLAG_BIT])
      else $error("pin flag not set");
  bo_flag_a: assert property (boRst |=> cause_r[rsc_pkg::BO_FLAG_BIT])
      else $error("brown-out flag not set");
  supply_flag_a: assert property (supRst |=> cause_r[rsc_pkg::SUP_FLAG_BIT])
      else $error("supply flag not set");
  bo_now_a: assert property ($rose(boRst) |-> coreReset ##1 coreReset_r && toutCnt_r == 0)
      else $error("brown-out reset delayed");
  wd_clear_a: assert property (watchdogResetInstr || !wdEn_r |=> wdCnt_r == 0)
      else $error("watchdog count not cleared");
  delay_restart_a: assert property (coreReset_r && toutCnt_r != 0 && srcActive
      |=> toutCnt_r == 0) else $error("delay not restarted");

  wd_reset_c: cover property (wdPulse_r ##1 coreReset_r);
  wd_off_c: cover property (wdEn_r && watchdog_turnoff_enable_r ##[1:4] !wdEn_r);
  sleep_c: cover property (sleepEnter);
  restart_c: cover property (coreReset_r && toutCnt_r > 0 ##1 srcActive);
  supply_c: cover property ($rose(supRst));

endmodule : rsc_reset_sleep

// [shared/rsc_pkg.sv]
// constants for the reset and sleep control block
package rsc_pkg;
  localparam int unsigned CLK_MHZ          = 125;
  // register byte offsets
  localparam logic [11:0] SLEEP_CTRL_OFS   = 12'h000;
  localparam logic [11:0] CAUSE_OFS        = 12'h004;
  localparam logic [11:0] WD_CTRL_OFS      = 12'h008;
  // power_sleep_control fields
  localparam int unsigned SLEEP_EN_BIT     = 7;
  localparam int unsigned SLEEP_MODE_LSB   = 4;
  localparam logic [7:0]  SLEEP_CTRL_RST   = 8'h00;
  // reset_cause_status fields
  localparam int unsigned JTAG_FLAG_BIT    = 4;
  localparam int unsigned WD_FLAG_BIT      = 3;
  localparam int unsigned BO_FLAG_BIT      = 2;
  localparam int unsigned PIN_FLAG_BIT     = 1;
  localparam int unsigned SUP_FLAG_BIT     = 0;
  localparam logic [4:0]  CAUSE_RST        = 5'h01;
  // watchdog control fields
  localparam int unsigned WD_TOE_BIT       = 4;
  localparam int unsigned WD_EN_BIT        = 3;
  localparam int unsigned WD_PRE_LSB       = 0;
  localparam logic [2:0]  WD_PRE_RST       = 3'h0;
  localparam logic [1:0]  TOE_LAST         = 2'h3;   // four cycles: 0..3
  localparam int unsigned WD_BASE_CYCLES   = 16384;
  // sleep mode codes
  localparam logic [2:0]  MODE_IDLE        = 3'h0;
  localparam logic [2:0]  MODE_NOISE       = 3'h1;
  localparam logic [2:0]  MODE_DOWN        = 3'h2;
  localparam logic [2:0]  MODE_SAVE        = 3'h3;
  localparam logic [2:0]  MODE_RSVD0       = 3'h4;
  localparam logic [2:0]  MODE_RSVD1       = 3'h5;
  localparam logic [2:0]  MODE_STBY        = 3'h6;
  localparam logic [2:0]  MODE_XSTBY       = 3'h7;
  // startup delay choices in microseconds and derived cycle counts
  localparam int unsigned TOUT0_US         = 1;
  localparam int unsigned TOUT1_US         = 100;
  localparam int unsigned TOUT2_US         = 1000;
  localparam int unsigned TOUT3_US         = 10000;
  localparam int unsigned TOUT0_CYCLES     = TOUT0_US * CLK_MHZ;
  localparam int unsigned TOUT1_CYCLES     = TOUT1_US * CLK_MHZ;
  localparam int unsigned TOUT2_CYCLES     = TOUT2_US * CLK_MHZ;
  localparam int unsigned TOUT3_CYCLES     = TOUT3_US * CLK_MHZ;
endpackage : rsc_pkg

// [tb/rsc_source_model.sv]
// far-side model: reset pin, supply and brown-out detectors, jtag level, watchdog oscillator
`timescale 1ns/1ps
module rsc_source_model (
  // clock
  input  wire logic clk,
  // reset sources
  output logic      resetPinN,
  output logic      supplyRiseDet,
  output logic      brownoutDet,
  output logic      jtagResetReg,
  output logic      wdOscClk
);
  // all sources idle at time zero
  initial begin
    resetPinN = 1'b1;
    supplyRiseDet = 1'b0;
    brownoutDet = 1'b0;
    jtagResetReg = 1'b0;
    wdOscClk = 1'b0;
  end
  // free-running, 66 ns period: well under a quarter of clk, phase unrelated to it
  always #33 wdOscClk = ~wdOscClk;
  // raise or drop one source, called right after a clock edge
  task automatic drive(input int k, input bit on);
    case (k)
      0: resetPinN <= ~on;
      1: supplyRiseDet <= on;
      2: brownoutDet <= on;
      default: jtagResetReg <= on;
    endcase
  endtask : drive
  // the pin is never pulsed shorter than three cycles, its minimum width here
  task automatic hold(input int k, input int n);
    drive(k, 1'b1);
    repeat ((k == 0 && n < 3) ? 3 : n) @(posedge clk);
    drive(k, 1'b0);
  endtask : hold
endmodule : rsc_source_model

// [tb/rsc_reset_sleep_bench.sv]
// self-checking bench for the reset and sleep control block
`timescale 1ns/1ps
module rsc_reset_sleep_bench;
  // bench-driven inputs and observed outputs
  logic        clk, rst, psel, penable, pwrite, extClockSel, sleepInstr;
  logic        watchdogResetInstr, compBandgapSel, converterEnable, brownoutEnableFuse;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [1:0]  startupDelayFuse;
  logic        pready, pslverr, resetPinN, supplyRiseDet, brownoutDet, jtagResetReg, wdOscClk;
  logic        ioPortReset, coreReset, sleepEnter, bandgapEnable;
  logic [2:0]  sleepMode;
  logic [32:0] rdQ[$];
  logic [2:0]  slQ[$];
  int          failures, checks, n0, n, d, f;

  // short delays (4,8,16,32) and watchdog base 8 keep the run brief
  rsc_reset_sleep #(.TOUT0_CYC(4), .TOUT1_CYC(8), .TOUT2_CYC(16), .TOUT3_CYC(32), .WD_BASE(8))
    dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .resetPinN, .supplyRiseDet, .brownoutDet, .jtagResetReg, .wdOscClk,
    .startupDelayFuse, .brownoutEnableFuse, .extClockSel, .sleepInstr, .watchdogResetInstr,
    .compBandgapSel, .converterEnable, .ioPortReset, .coreReset, .sleepEnter, .sleepMode,
    .bandgapEnable);
  rsc_source_model src_u (.clk, .resetPinN, .supplyRiseDet, .brownoutDet, .jtagResetReg,
    .wdOscClk);

  always #4 clk = ~clk;

  task automatic chkVal(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chkVal

  // reads compare error flag and data together
  task automatic chkReg(input logic [32:0] e, input logic [32:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] prdata expected %h seen %h", e, g);
    end
  endtask : chkReg

  // one apb transfer; keep leaves the bus selected for a back-to-back follower
  task automatic apb(input bit w, input logic [11:0] a, input logic [7:0] v,
                     input bit keep = 0, input bit err = 0);
    int k;
    if (!w) rdQ.push_back({err, 24'h0, err ? 8'h00 : v});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    // an idle edge after release avoids re-driving psel in the same step
    if (!keep) begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask : apb

  // cycles until the internal reset falls, bounded
  task automatic waitRel(output int c);
    c = 0;
    while (coreReset !== 1'b0 && c < 20000) begin
      @(posedge clk);
      c++;
    end
  endtask : waitRel

  // bandgap follows its three inputs, checked three cycles after each change
  task automatic bgCheck(input bit fuse);
    for (int i = 0; i < 4; i++) begin
      compBandgapSel <= i[0];
      converterEnable <= i[1];
      repeat (3) @(posedge clk);
      chkVal("bandgapEnable", fuse | i[0] | i[1], bandgapEnable);
    end
  endtask : bgCheck

  task automatic conclude();
    failures += rdQ.size() + slQ.size();
    if (failures == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // watcher: each completed read and each sleep entry takes the oldest note
  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (rdQ.size() == 0) chkVal("stray read", 0, 1);
      else chkReg(rdQ.pop_front(), {pslverr, prdata});
    end
    if (sleepEnter !== 1'b0) begin
      if (slQ.size() == 0) chkVal("sleepEnter", 0, 1);
      else chkVal("sleepMode", slQ.pop_front(), sleepMode);
    end
  end

  // cut a hang short well past the expected run length
  initial begin
    #480000;
    failures++;
    conclude();
  end

  initial begin
    clk = 0;
    rst = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    extClockSel = 0;
    sleepInstr = 0;
    watchdogResetInstr = 0;
    compBandgapSel = 0;
    converterEnable = 0;
    brownoutEnableFuse = 0;
    startupDelayFuse = 2'h1;
    failures = 0;
    checks = 0;
    void'($urandom(3246));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    waitRel(n);
    // initial values, an unmapped word, clearing the cause flags
    apb(0, 12'h000, 8'h00);
    apb(0, 12'h004, 8'h01);
    apb(0, 12'h008, 8'h00);
    apb(0, 12'h00c, 8'h00, 0, 1);
    apb(1, 12'h00c, 8'hff, 1);
    apb(1, 12'h004, 8'h00);
    apb(0, 12'h004, 8'h00);
    // every mode code, with and without enable; crystal option random
    for (int i = 0; i < 16; i++) begin
      d = {i[0], i[3:1], 4'($urandom)};
      extClockSel <= 1'($urandom);
      apb(1, 12'h000, d[7:0], 1);
      apb(0, 12'h000, d[7:0]);
      sleepInstr <= 1'b1;
      @(posedge clk);
      sleepInstr <= 1'b0;
      if (i[0] && i[3:2] != 2'b10 && (i[3:2] != 2'b11 || extClockSel)) slQ.push_back(i[3:1]);
      repeat (3) @(posedge clk);
      chkVal("sleep notes left", 0, slQ.size());
    end
    apb(1, 12'h000, 8'h00);  // enable cleared after waking
    // startup delay per fuse code, measured from pin release
    for (f = 0; f < 4; f++) begin
      startupDelayFuse <= f[1:0];
      src_u.drive(0, 1'b1);
      @(posedge clk);
      #1 chkVal("ioPortReset", 1, ioPortReset);
      src_u.hold(0, 4);
      waitRel(n);
      if (f == 0) n0 = n;
      chkVal("startup delay", (4 << f) - 4, n - n0);
      apb(0, 12'h004, 8'h02);
      apb(1, 12'h004, 8'h00);
    end
    // a second pulse during the delay restarts it
    src_u.hold(0, 4);
    repeat (10) @(posedge clk);
    src_u.hold(0, 3);
    waitRel(d);
    chkVal("restarted delay", n, d);
    // jtag level holds the internal reset all along
    src_u.drive(3, 1'b1);
    repeat (40) @(posedge clk);
    chkVal("coreReset", 1, coreReset);
    src_u.drive(3, 1'b0);
    waitRel(d);
    chkVal("jtag delay", n, d);
    apb(0, 12'h004, 8'h12);
    apb(1, 12'h004, 8'h00);
    // brown-out ignored with its fuse off, acts once the fuse is captured on
    bgCheck(0);
    src_u.hold(2, 10);
    chkVal("coreReset", 0, coreReset);
    brownoutEnableFuse <= 1'b1;
    src_u.hold(0, 4);
    waitRel(d);
    bgCheck(1);
    src_u.drive(2, 1'b1);
    repeat (3) @(posedge clk);
    chkVal("coreReset", 1, coreReset);
    src_u.drive(2, 1'b0);
    waitRel(d);
    chkVal("brown-out delay", n, d);
    apb(0, 12'h004, 8'h06);
    // supply rise reasserts at once and leaves only its own flag
    src_u.drive(1, 1'b1);
    repeat (3) @(posedge clk);
    chkVal("coreReset", 1, coreReset);
    src_u.drive(1, 1'b0);
    waitRel(d);
    apb(0, 12'h004, 8'h01);
    apb(1, 12'h004, 8'h00);
    // plain disable refused; timed sequence works; a late second write is refused
    apb(1, 12'h008, 8'h0f);
    apb(1, 12'h008, 8'h07);
    apb(0, 12'h008, 8'h0f);
    apb(1, 12'h008, 8'h1f, 1);
    apb(1, 12'h008, 8'h07);
    apb(0, 12'h008, 8'h17);  // turn-off bit still armed at this read
    apb(1, 12'h008, 8'h0f);
    apb(1, 12'h008, 8'h1f);
    repeat (6) @(posedge clk);
    apb(1, 12'h008, 8'h07);
    apb(0, 12'h008, 8'h0f);
    apb(1, 12'h008, 8'h1f, 1);
    apb(1, 12'h008, 8'h00);
    // each prescale code; the first is also kept alive by the clear instruction
    for (int p = 0; p < 8; p++) begin
      apb(1, 12'h008, 8'h08 | p[7:0]);
      if (p == 0) begin
        repeat (10) begin
          repeat (30) @(posedge clk);
          watchdogResetInstr <= 1'b1;
          @(posedge clk);
          watchdogResetInstr <= 1'b0;
        end
        apb(0, 12'h004, 8'h00);
      end
      d = 0;
      while (coreReset !== 1'b1 && d < 20000) begin
        @(posedge clk);
        d++;
      end
      chkVal("watchdog period", 1, d > (66 << p) - 30 && d < (66 << p) + 30);
      waitRel(n);
      apb(0, 12'h004, 8'h08);
      apb(1, 12'h004, 8'h00);
    end
    conclude();
  end
endmodule : rsc_reset_sleep_bench
